// ==== hdl/sbt_defs.vh ====
// Constants for the sixteen bit timer: register offsets, field positions, codes.
// Assumes inclusion by bare name from the timer design file only.
`ifndef SBT_DEFS_VH
`define SBT_DEFS_VH
`define SBT_IDX_MODE        8'h06
`define SBT_IDX_EDGE        8'h0C
`define SBT_IDX_CNT         8'h10
`define SBT_IDX_FLAG        8'h11
`define SBT_ADDR_W          12
`define SBT_SRC_HI          7
`define SBT_SRC_LO          5
`define SBT_PRE_HI          4
`define SBT_PRE_LO          3
`define SBT_BIT_HI          2
`define SBT_BIT_LO          0
`define SBT_EDGE_BIT        5
`define SBT_FLAG_BIT        2
`define SBT_SRC_STOP        3'h0
`define SBT_SRC_SYS         3'h1
`define SBT_SRC_RSVD        3'h2
`define SBT_SRC_PA4         3'h3
`define SBT_SRC_HIGH_RC     3'h4
`define SBT_SRC_XTAL        3'h5
`define SBT_SRC_LOW_RC      3'h6
`define SBT_SRC_PA0         3'h7
`define SBT_BASE_BIT        4'h8
`define SBT_MODE_RST        8'h00
`define SBT_EDGE_RST        8'h00
`define SBT_RESP_OKAY       2'h0
`define SBT_RESP_SLVERR     2'h2
`endif

// ==== hdl/sbt_timer.v ====
// Sixteen bit up-counting timer with clock source select, prescaler and bit-edge event.
// Assumes an AXI4-Lite master on SYS_CLK; oscillator and pin clocks arrive as asynchronous
// levels and are sampled, so each must run below a quarter of SYS_CLK.
//
// Function
// [RL1] Mode bits 7..5 pick the clock: stop, sys, reserved, A4, high RC, crystal, low RC, A0.
// [RL2] Mode bits 4..3 divide the chosen clock by 1, 4, 16 or 64.
// [RL3] Mode bits 2..0 pick counter bit 8 through 15 as the event source.
// [RL4] Counter counts up one per prescaled tick and holds while stopped.
// [RL5] Store writes a 16-bit start value; load reads the current count.
// [RL6] Edge register bit 5 at 0x0C picks rising or falling event transition.
// [RL7] The event sets flag bit 2 of the interrupt request register.
// [RL8] Free-running event rate is source over prescale over two to n plus one.
// [RL9] Overflow seen at the selected bit raises the event; mux feeds prescaler.
// [RL10] Counter wraps from 0xFFFF to 0x0000 and keeps counting.
`include "sbt_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module sbt_timer (
  input  wire        SYS_CLK,
  input  wire        RST,
  input  wire        EXT_XTAL_CLK,
  input  wire        INTERNAL_HIGH_RC_CLOCK,
  input  wire        INTERNAL_LOW_RC_CLOCK,
  input  wire        PIN_A4,
  input  wire        PIN_A0,
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output wire        TIMER_EVENT
);
  // Asynchronous clock levels: two flops each, then an edge detector on the second.
  wire [4:0] async_in;
  reg  [4:0] sync1_q;
  reg  [4:0] sync2_q;
  reg  [4:0] sync3_q;
  wire [4:0] rise;
  assign async_in = {PIN_A0, INTERNAL_LOW_RC_CLOCK, EXT_XTAL_CLK, INTERNAL_HIGH_RC_CLOCK, PIN_A4};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sync
      always @(posedge SYS_CLK) begin
        if (RST) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= async_in[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
        end
      end
      assign rise[g] = sync2_q[g] & ~sync3_q[g];
    end
  endgenerate

  reg  [7:0]  mode_q;
  reg  [7:0]  mode_d;
  reg  [7:0]  edge_q;
  reg  [7:0]  edge_d;
  reg  [15:0] cnt_q;
  reg  [15:0] cnt_d;
  reg         flag_q;
  reg         flag_d;
  reg  [5:0]  pre_q;
  reg  [5:0]  pre_d;
  reg         sel_bit_q;
  reg         sel_bit_d;

  wire [15:0] load_val;
  wire [2:0]  src;
  wire [1:0]  pre_sel;
  wire [2:0]  bit_sel;
  wire [3:0]  bit_idx;
  reg         src_tick;
  reg         pre_tick;
  wire        sel_bit;
  wire        sel_rise;
  wire        sel_fall;
  wire        load_bit;
  wire        evt;
  wire        clr_flag;

  assign src     = mode_q[`SBT_SRC_HI:`SBT_SRC_LO];
  assign pre_sel = mode_q[`SBT_PRE_HI:`SBT_PRE_LO];
  assign bit_sel = mode_q[`SBT_BIT_HI:`SBT_BIT_LO];
  assign bit_idx = `SBT_BASE_BIT + {1'b0, bit_sel}; // RL3

  // The reserved code behaves as stopped so no undefined clock reaches the counter.
  always @* begin
    case (src) // RL1 RL9
      `SBT_SRC_SYS:     src_tick = 1'b1;
      `SBT_SRC_PA4:     src_tick = rise[0];
      `SBT_SRC_HIGH_RC: src_tick = rise[1];
      `SBT_SRC_XTAL:    src_tick = rise[2];
      `SBT_SRC_LOW_RC:  src_tick = rise[3];
      `SBT_SRC_PA0:     src_tick = rise[4];
      default:          src_tick = 1'b0;
    endcase
  end

  // The prescaler runs free on source ticks; only the low bits of the chosen ratio matter.
  always @* begin
    case (pre_sel) // RL2
      2'h0:    pre_tick = src_tick;
      2'h1:    pre_tick = src_tick & (pre_q[1:0] == 2'h3);
      2'h2:    pre_tick = src_tick & (pre_q[3:0] == 4'hF);
      default: pre_tick = src_tick & (pre_q == 6'h3F);
    endcase
  end

  assign sel_bit  = cnt_q[bit_idx]; // RL3
  assign sel_rise = ~sel_bit_q & sel_bit;
  assign sel_fall = sel_bit_q & ~sel_bit;
  // Rising or falling transition of the chosen bit, per edge register bit 5.
  assign evt = edge_q[`SBT_EDGE_BIT] ? sel_fall : sel_rise; // RL6 RL8 RL9
  assign TIMER_EVENT = flag_q;

  // Bus slave: one write and one read at a time; address and data taken together.
  // Taking both halves of a write at one edge keeps the slave free of a holding buffer.
  wire        aw_go;
  wire        ar_go;
  wire        wr_cnt;
  wire [7:0]  widx;
  wire [7:0]  ridx;
  reg         rd_hit;
  reg         wr_hit;
  reg         bvalid_d;
  reg  [1:0]  bresp_d;
  reg         rvalid_d;
  reg  [1:0]  rresp_d;
  reg  [31:0] rdata_d;
  reg  [31:0] rd_word;

  assign S_AXI_AWREADY = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = S_AXI_AWREADY;
  assign aw_go         = S_AXI_AWREADY;
  assign S_AXI_ARREADY = S_AXI_ARVALID & ~S_AXI_RVALID;
  assign ar_go         = S_AXI_ARREADY;
  assign widx   = S_AXI_AWADDR[9:2];
  assign ridx   = S_AXI_ARADDR[9:2];
  assign wr_cnt = aw_go & (widx == `SBT_IDX_CNT);

  always @* begin
    case (widx)
      `SBT_IDX_MODE: wr_hit = 1'b1;
      `SBT_IDX_EDGE: wr_hit = 1'b1;
      `SBT_IDX_CNT:  wr_hit = 1'b1;
      `SBT_IDX_FLAG: wr_hit = 1'b1;
      default:       wr_hit = 1'b0;
    endcase
  end

  always @* begin
    case (ridx)
      `SBT_IDX_MODE: rd_hit = 1'b1;
      `SBT_IDX_EDGE: rd_hit = 1'b1;
      `SBT_IDX_CNT:  rd_hit = 1'b1;
      `SBT_IDX_FLAG: rd_hit = 1'b1;
      default:       rd_hit = 1'b0;
    endcase
  end

  always @* begin
    mode_d = mode_q;
    if (aw_go && S_AXI_WSTRB[0] && widx == `SBT_IDX_MODE) begin
      mode_d = S_AXI_WDATA[7:0]; // RL1 RL2 RL3
    end
  end

  always @* begin
    edge_d = edge_q;
    if (aw_go && S_AXI_WSTRB[0] && widx == `SBT_IDX_EDGE) begin
      edge_d = S_AXI_WDATA[7:0]; // RL6
    end
  end

  assign load_val = {S_AXI_WSTRB[1] ? S_AXI_WDATA[15:8] : cnt_q[15:8],
                     S_AXI_WSTRB[0] ? S_AXI_WDATA[7:0]  : cnt_q[7:0]}; // RL5
  assign load_bit = load_val[bit_idx];

  // A store restarts the prescaler so the first tick after it is full length.
  always @* begin
    cnt_d     = cnt_q;
    pre_d     = pre_q;
    sel_bit_d = sel_bit;
    if (wr_cnt) begin
      cnt_d     = load_val; // RL5
      pre_d     = 6'h00;
      // The loaded value becomes the new reference, so the load itself fires no event.
      sel_bit_d = load_bit;
    end else begin
      if (src_tick) begin
        pre_d = pre_q + 6'h01;
      end
      if (pre_tick) begin
        cnt_d = cnt_q + 16'h0001; // RL4 RL10
      end
    end
  end

  // Set wins over a clear written in the same cycle.
  assign clr_flag = aw_go && (widx == `SBT_IDX_FLAG) && S_AXI_WSTRB[0] &&
                    S_AXI_WDATA[`SBT_FLAG_BIT];
  always @* begin
    flag_d = flag_q;
    if (evt & ~wr_cnt) begin
      flag_d = 1'b1; // RL7
    end else if (clr_flag) begin
      flag_d = 1'b0;
    end
  end

  always @* begin
    bvalid_d = S_AXI_BVALID;
    bresp_d  = S_AXI_BRESP;
    if (aw_go) begin
      bvalid_d = 1'b1;
      bresp_d  = wr_hit ? `SBT_RESP_OKAY : `SBT_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
  end

  always @* begin
    case (ridx)
      `SBT_IDX_MODE: rd_word = {24'h000000, mode_q};
      `SBT_IDX_EDGE: rd_word = {24'h000000, edge_q};
      `SBT_IDX_CNT:  rd_word = {16'h0000, cnt_q}; // RL5
      `SBT_IDX_FLAG: rd_word = {29'h0000000, flag_q, 2'h0};
      default:       rd_word = 32'h00000000;
    endcase
  end

  always @* begin
    rvalid_d = S_AXI_RVALID;
    rresp_d  = S_AXI_RRESP;
    rdata_d  = S_AXI_RDATA;
    if (ar_go) begin
      rvalid_d = 1'b1;
      rresp_d  = rd_hit ? `SBT_RESP_OKAY : `SBT_RESP_SLVERR;
      rdata_d  = rd_word;
    end else if (S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      mode_q <= `SBT_MODE_RST;
      edge_q <= `SBT_EDGE_RST;
    end else begin
      mode_q <= mode_d;
      edge_q <= edge_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      cnt_q     <= 16'h0000;
      pre_q     <= 6'h00;
      sel_bit_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      pre_q     <= pre_d;
      sel_bit_q <= sel_bit_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `SBT_RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP  <= `SBT_RESP_OKAY;
      S_AXI_RDATA  <= 32'h00000000;
    end else begin
      S_AXI_BVALID <= bvalid_d;
      S_AXI_BRESP  <= bresp_d;
      S_AXI_RVALID <= rvalid_d;
      S_AXI_RRESP  <= rresp_d;
      S_AXI_RDATA  <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ==== verif/sbt_timer_props.sv ====
// Bus handshake and event flag checks for the sixteen bit timer.
// Assumes binding to sbt_timer, with SYS_CLK as the only clock.
`timescale 1ns/1ps
`default_nettype none
module sbt_timer_props (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic TIMER_EVENT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Only a taken write can clear the flag, so it is excluded below.
  wire aw = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  property p_b; aw |=> S_AXI_BVALID; endproperty
  a_b: assert property (p_b) else $error("write answer late");
  property p_bh; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
  a_bh: assert property (p_bh) else $error("write answer dropped");
  property p_bc; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_bc: assert property (p_bc) else $error("write answer stuck");
  property p_wr; S_AXI_AWREADY == aw && S_AXI_WREADY == aw; endproperty
  a_wr: assert property (p_wr) else $error("write ready wrong");
  property p_r; S_AXI_ARVALID && !S_AXI_RVALID |=> S_AXI_RVALID; endproperty
  a_r: assert property (p_r) else $error("read answer late");
  property p_rh; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RVALID); endproperty
  a_rh: assert property (p_rh) else $error("read answer dropped");
  property p_ar; S_AXI_ARREADY == (S_AXI_ARVALID && !S_AXI_RVALID); endproperty
  a_ar: assert property (p_ar) else $error("read ready wrong");
  property p_ev; TIMER_EVENT && !aw |=> TIMER_EVENT; endproperty
  a_ev: assert property (p_ev) else $error("event flag lost");
  property p_rs; $fell(RST) |-> !TIMER_EVENT; endproperty
  a_rs: assert property (p_rs) else $error("event flag after reset");
endmodule
`default_nettype wire

// ==== verif/sbt_timer_bench.sv ====
// Bench for the sixteen bit timer: register rows, then timed event runs.
// Assumes sbt_timer; slow source clocks come from a divider of SYS_CLK.
`timescale 1ns/1ps
`default_nettype none
module sbt_timer_bench;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r;} sbt_row_t;
  sbt_row_t    rows [6] = '{'{12'h018, 32'hFFFFFF1C, 32'h1C, 2'h0}, '{12'h030, 32'h20, 32'h20, 2'h0},
    '{12'h040, 32'hABCD1234, 32'h1234, 2'h0}, '{12'h044, 32'h0, 32'h0, 2'h0},
    '{12'h07C, 32'h5A, 32'h0, 2'h2}, '{12'h030, 32'h0, 32'h0, 2'h0}};
  logic        SYS_CLK = 1'h0, RST = 1'h1, S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0;
  logic        S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  logic [11:0] S_AXI_AWADDR = 12'h0, S_AXI_ARADDR = 12'h0;
  logic [31:0] S_AXI_WDATA = 32'h0, d_q;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic [6:0]  dv = 7'h0;
  logic [1:0]  b_q, r_q;
  wire logic   EXT_XTAL_CLK = dv[4], INTERNAL_HIGH_RC_CLOCK = dv[3];
  wire logic   INTERNAL_LOW_RC_CLOCK = dv[5];
  wire logic   PIN_A4 = dv[2], PIN_A0 = dv[6];
  wire logic   S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, TIMER_EVENT;
  wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  wire logic [31:0] S_AXI_RDATA;
  int          n_mismatch = 0, checks = 0, p;
  sbt_timer i_sbt_timer (.*);
  always #12.5 SYS_CLK = ~SYS_CLK;
  // Each source gets its own rate, so a wrong selection shows as a wrong delay.
  always @(posedge SYS_CLK) dv <= dv + 7'h01;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    do @(posedge SYS_CLK); while (S_AXI_AWREADY !== 1'h1);
    S_AXI_AWVALID <= 1'h0;
    S_AXI_WVALID <= 1'h0;
    do @(posedge SYS_CLK); while (S_AXI_BVALID !== 1'h1);
    S_AXI_BREADY <= 1'h0;
    b_q = S_AXI_BRESP;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    do @(posedge SYS_CLK); while (S_AXI_ARREADY !== 1'h1);
    S_AXI_ARVALID <= 1'h0;
    do @(posedge SYS_CLK); while (S_AXI_RVALID !== 1'h1);
    S_AXI_RREADY <= 1'h0;
    d_q = S_AXI_RDATA;
    r_q = S_AXI_RRESP;
  endtask
  task automatic run(input logic [15:0] c, input logic [7:0] m, input int lo, input int hi,
                     input logic e);
    int n;
    n = 0;
    wr(12'h018, 32'h0);
    wr(12'h040, {16'h0, c});
    wr(12'h044, 32'h4);
    wr(12'h018, {24'h0, m});
    while (TIMER_EVENT !== 1'h1 && n < hi) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("event delay", 32'(TIMER_EVENT === e && n >= lo), 32'h1);
    if (e === 1'h0) begin
      rd(12'h040);
      chk("held count", d_q, {16'h0, c});
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    results;
  end
  initial begin
    repeat (4) @(posedge SYS_CLK);
    RST <= 1'h0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk("bresp", 32'(b_q), 32'(rows[i].r));
      rd(rows[i].a);
      chk("rresp", 32'(r_q), 32'(rows[i].r));
      chk("rdata", d_q, rows[i].e);
    end
    for (int c = 0; c < 8; c++) begin
      p = (c < 3) ? 1 : 8 << (c - 3);
      if (c == 1 || c > 2) run(16'h00F0, 8'(c << 5), 15 * p - 3, 17 * p + 4, 1'h1);
      else run(16'h00F0, 8'(c << 5), 0, 300, 1'h0);
    end
    for (int q = 1; q < 4; q++) run(16'h00F0, 8'h20 | 8'(q << 3), (16 << 2 * q) - 3,
                                    (16 << 2 * q) + 3, 1'h1);
    for (int b = 0; b < 8; b++) run(16'(32'h100 << b) - 16'h0010, 8'h20 | 8'(b), 13, 19, 1'h1);
    wr(12'h030, 32'h20);
    run(16'hFFF0, 8'h27, 13, 19, 1'h1);
    rd(12'h044);
    chk("flag", d_q, 32'h4);
    wr(12'h044, 32'h4);
    chk("flag cleared", 32'(TIMER_EVENT), 32'h0);
    RST <= 1'h1;
    @(posedge SYS_CLK);
    RST <= 1'h0;
    rd(12'h018);
    chk("mode after reset", d_q, 32'h0);
    results;
  end
endmodule
bind sbt_timer sbt_timer_props i_sbt_timer_props (.*);
`default_nettype wire
